// [common/cbse_regs.vh]
// Register map, command fields, opcodes, flag positions and cycle counts
// for the branch, bit, shift and pointer-load execution block.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
`ifndef CBSE_REGS_VH
`define CBSE_REGS_VH

// Register byte offsets
`define CBSE_ADDR_W 8
`define CBSE_OFS_CMD 8'h00
`define CBSE_OFS_STATUS 8'h04
`define CBSE_OFS_FLAGS 8'h08
`define CBSE_OFS_PC 8'h0c
`define CBSE_OFS_DATA 8'h10
`define CBSE_OFS_XPTR 8'h14
// I/O register window 0x20..0x3c, data window 0x40..0x7c
`define CBSE_IO_BASE_TAG 3'b001
`define CBSE_MEM_BASE_TAG 2'b01
`define CBSE_IO_COUNT 8
`define CBSE_MEM_COUNT 16

// Command word fields
`define CBSE_F_OP_MSB 4
`define CBSE_F_OP_LSB 0
`define CBSE_F_BIT_MSB 10
`define CBSE_F_BIT_LSB 8
`define CBSE_F_IO_MSB 14
`define CBSE_F_IO_LSB 12
`define CBSE_F_OFS_MSB 22
`define CBSE_F_OFS_LSB 16
`define CBSE_CMD_MASK 32'h007f771f

// Status word fields
`define CBSE_ST_BUSY 0
`define CBSE_ST_TAKEN 1

// Opcodes
`define CBSE_OP_NOP 5'h00
`define CBSE_OP_BR_SET 5'h01
`define CBSE_OP_BR_CLR 5'h02
`define CBSE_OP_IO_SET 5'h03
`define CBSE_OP_IO_CLR 5'h04
`define CBSE_OP_LSL 5'h05
`define CBSE_OP_LSR 5'h06
`define CBSE_OP_ROL 5'h07
`define CBSE_OP_ROR 5'h08
`define CBSE_OP_ASHR 5'h09
`define CBSE_OP_SWAP 5'h0a
`define CBSE_OP_FLAG_SET 5'h0b
`define CBSE_OP_FLAG_CLR 5'h0c
`define CBSE_OP_TSTORE 5'h0d
`define CBSE_OP_TLOAD 5'h0e
`define CBSE_OP_LD_X 5'h0f
`define CBSE_OP_LD_XINC 5'h10
`define CBSE_OP_LD_XDEC 5'h11

// Status flag register bit positions
`define CBSE_FL_C 0
`define CBSE_FL_Z 1
`define CBSE_FL_N 2
`define CBSE_FL_V 3
`define CBSE_FL_S 4
`define CBSE_FL_H 5
`define CBSE_FL_T 6
`define CBSE_FL_I 7

// Reset values
`define CBSE_FLAGS_RST 8'h00
`define CBSE_PC_RST 16'h0000
`define CBSE_X_RST 16'h0000
`define CBSE_DATA_RST 8'h00
`define CBSE_CMD_RST 32'h00000000
`define CBSE_STORE_RST 8'h00

// Execution lengths in core cycles
`define CBSE_CYC_SHORT 1
`define CBSE_CYC_LONG 2

`endif

// [dv/cbse_exec_chk.sv]
// Port-level checker for the execution block's APB side.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns

module cbse_exec_chk (
    input logic clock,
    input logic reset_n,
    input logic clock_en,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Answer lasts one cycle, so no access is acknowledged twice
    property p_pulse; pready && clock_en |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held past one cycle");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_in_access; pready |-> psel && penable; endproperty
    a_in_access: assert property (p_in_access) else $error("pready outside access");
    // Reads never wait on a running instruction
    property p_read_wait; psel && penable && !pwrite && !pready && clock_en |=> pready;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer late");
    // A write stalled by a running instruction waits at most two extra cycles
    property p_write_bound; psel && penable && pwrite && !pready && clock_en |-> ##[1:3] pready;
    endproperty
    a_write_bound: assert property (p_write_bound)
        else $error("write stall too long");
    property p_misalign; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
    property p_unmapped; pready && (paddr[7] || paddr[7:3] == 5'b00011) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_mapped; pready && paddr[1:0] == 2'b00 && !paddr[7]
        && paddr[7:3] != 5'b00011 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_wr_zero; pready && pwrite |-> prdata == 32'h00000000; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("prdata not zero on write");
    // A low clock enable freezes the answer signals
    property p_frozen; !clock_en |=> $stable(pready) && $stable(prdata) && $stable(pslverr);
    endproperty
    a_frozen: assert property (p_frozen) else $error("outputs moved while frozen");
endmodule

bind cbse_exec cbse_exec_chk u_chk (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [dv/cbse_exec_tb.sv]
// Self-checking bench for the execution block, all traffic over APB.
// Assumes the block answers each access itself; every wait is bounded.
`timescale 1ns/1ns
`include "cbse_regs.vh"

module cbse_exec_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clock_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int failures = 0;
    int checked = 0;
    logic [7:0] e_sr, e_d, e_io, m0, m1;
    logic [15:0] e_pc, e_x;
    logic e_tk;
    logic [31:0] rv;
    logic er;
    int e_cyc;
    int polls;

    cbse_exec uut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Core clock, 50 ns period
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic summarize;
        begin
            $display("checked %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checked++;
            if (g !== e) begin
                failures++;
                $display("wrong value %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // One transfer; psel stays up so a following setup can come at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            do begin
                @(posedge clock);
                n++;
            end while (pready !== 1'b1 && n < 20);
            rv = prdata;
            er = pslverr;
            penable <= 1'b0;
            if (n >= 20) begin
                failures++;
                summarize();
            end
        end
    endtask

    // Start an instruction, optionally queue a second one behind it, then poll busy
    task automatic exec(input logic [31:0] cmd, input logic ex);
        int n;
        begin
            apb(1'b1, `CBSE_OFS_CMD, cmd);
            if (ex) begin
                apb(1'b1, `CBSE_OFS_CMD, 32'h00000000);
            end
            n = 0;
            rv = 32'h00000001;
            while (rv[0] !== 1'b0 && n < 10) begin
                apb(1'b0, `CBSE_OFS_STATUS, 32'h00000000);
                n++;
            end
            // First poll lands in the second execution cycle
            polls = n;
            if (n >= 10) begin
                failures++;
                summarize();
            end
        end
    endtask

    // Expected state after one instruction
    function automatic void model(input logic [4:0] op, input logic [2:0] b, input logic [6:0] k);
        logic c;
        logic f;
        begin
            c = e_sr[0];
            f = (b == 3'h4) ? e_sr[2] ^ e_sr[3] : e_sr[b];
            e_tk = 1'b0;
            e_cyc = `CBSE_CYC_SHORT;
            e_pc = e_pc + 16'h0001;
            case (op)
                5'h01, 5'h02: begin
                    e_tk = (op == 5'h01) ? f : !f;
                    if (e_tk) e_pc = e_pc + {{9{k[6]}}, k};
                end
                5'h03: e_io[b] = 1'b1;
                5'h04: e_io[b] = 1'b0;
                5'h05: {c, e_d} = {e_d, 1'b0};
                5'h06: {e_d, c} = {1'b0, e_d};
                5'h07: {c, e_d} = {e_d, c};
                5'h08: {e_d, c} = {c, e_d};
                5'h09: {e_d, c} = {e_d[7], e_d};
                5'h0a: e_d = {e_d[3:0], e_d[7:4]};
                5'h0b: e_sr[b] = 1'b1;
                5'h0c: e_sr[b] = 1'b0;
                5'h0d: e_sr[6] = e_d[b];
                5'h0e: e_d[b] = e_sr[6];
                5'h0f: e_d = m0;
                5'h10: begin
                    e_d = m0;
                    e_x = e_x + 16'h0001;
                end
                5'h11: begin
                    e_x = e_x - 16'h0001;
                    e_d = m1;
                end
                default: e_tk = 1'b0;
            endcase
            // Shifts set Z C N and V = N xor C
            if (op >= 5'h05 && op <= 5'h09) begin
                e_sr[3:0] = {e_d[7] ^ c, e_d[7], e_d == 8'h00, c};
            end
            // I/O bit ops, loads and taken branches take the long path
            if (e_tk || op == 5'h03 || op == 5'h04 || (op >= 5'h0f && op <= 5'h11)) begin
                e_cyc = `CBSE_CYC_LONG;
            end
        end
    endfunction

    initial begin
        logic [4:0] op;
        logic [2:0] b, io;
        logic [6:0] k;
        logic ex;
        void'($urandom(32'ha9894e39));
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, `CBSE_OFS_FLAGS, 32'h00000000);
        chk("flags_reset", 32'h00000000, rv);
        apb(1'b0, 8'h18, 32'h00000000);
        chk("unmapped_err", 32'h00000001, {31'h0, er});
        apb(1'b0, 8'h05, 32'h00000000);
        chk("misaligned_err", 32'h00000001, {31'h0, er});
        for (int i = 0; i < 400; i++) begin
            e_sr = $urandom;
            e_d = $urandom;
            e_pc = $urandom;
            e_x = $urandom;
            e_io = $urandom;
            m0 = $urandom;
            m1 = $urandom;
            op = $urandom_range(18, 0);
            if (op == 5'd18) op = 5'h1f;
            b = $urandom;
            io = $urandom;
            k = $urandom;
            ex = ($urandom_range(3, 0) == 0);
            apb(1'b1, `CBSE_OFS_FLAGS, {24'h0, e_sr});
            apb(1'b1, `CBSE_OFS_DATA, {24'h0, e_d});
            apb(1'b1, `CBSE_OFS_PC, {16'h0, e_pc});
            apb(1'b1, `CBSE_OFS_XPTR, {16'h0, e_x});
            apb(1'b1, {3'b001, io, 2'b00}, {24'h0, e_io});
            apb(1'b1, {2'b01, e_x[3:0], 2'b00}, {24'h0, m0});
            apb(1'b1, {2'b01, e_x[3:0] - 4'h1, 2'b00}, {24'h0, m1});
            model(op, b, k);
            if (ex) model(5'h00, b, k);
            exec({9'h0, k, 1'b0, io, 1'b0, b, 3'h0, op}, ex);
            if (!ex) begin
                chk("cycles", e_cyc, polls);
            end
            if (!ex && (op == 5'h01 || op == 5'h02)) begin
                chk("taken", {31'h0, e_tk}, {31'h0, rv[1]});
            end
            apb(1'b0, `CBSE_OFS_PC, 32'h00000000);
            chk("pc", {16'h0, e_pc}, rv);
            apb(1'b0, `CBSE_OFS_FLAGS, 32'h00000000);
            chk("flags", {24'h0, e_sr}, rv);
            apb(1'b0, `CBSE_OFS_DATA, 32'h00000000);
            chk("data", {24'h0, e_d}, rv);
            apb(1'b0, `CBSE_OFS_XPTR, 32'h00000000);
            chk("xptr", {16'h0, e_x}, rv);
            apb(1'b0, {3'b001, io, 2'b00}, 32'h00000000);
            chk("io_reg", {24'h0, e_io}, rv);
        end
        // Freeze a taken carry branch before its first execution cycle; it must resume and finish
        apb(1'b1, `CBSE_OFS_FLAGS, 32'h00000001);
        apb(1'b1, `CBSE_OFS_PC, 32'h00000100);
        apb(1'b1, `CBSE_OFS_CMD, 32'h00050001);
        psel <= 1'b0;
        clock_en <= 1'b0;
        repeat (6) @(posedge clock);
        clock_en <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, `CBSE_OFS_PC, 32'h00000000);
        chk("pc_frozen", 32'h00000106, rv);
        apb(1'b0, `CBSE_OFS_STATUS, 32'h00000000);
        chk("status_frozen", 32'h00000002, rv);
        // Reset after the branch has finished returns the state to its reset values
        psel <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, `CBSE_OFS_STATUS, 32'h00000000);
        chk("status_reset", 32'h00000000, rv);
        apb(1'b0, `CBSE_OFS_PC, 32'h00000000);
        chk("pc_reset", 32'h00000000, rv);
        apb(1'b0, `CBSE_OFS_XPTR, 32'h00000000);
        chk("x_reset", 32'h00000000, rv);
        apb(1'b0, `CBSE_OFS_DATA, 32'h00000000);
        chk("data_reset", 32'h00000000, rv);
        apb(1'b0, `CBSE_OFS_FLAGS, 32'h00000000);
        chk("flags_after_reset", 32'h00000000, rv);
        psel <= 1'b0;
        @(posedge clock);
        summarize();
    end
endmodule

// [rtl/cbse_exec.v]
// Execution block for branches, I/O bit ops, shifts, flag ops, T-bit
// transfers and X-pointer loads, with its state reached over APB.
// Assumes APB signals come from logic on the same clock.
`timescale 1ns/1ns
`include "cbse_regs.vh"

module cbse_exec (
    input wire clock,
    input wire reset_n,
    input wire clock_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);

    // Register map, byte offsets on paddr:
    //   Command word at the base, a write starts one instruction
    //   Status word: bit 0 busy, bit 1 set if the last instruction was a taken branch
    //   Flag register, program counter, operand register, X pointer
    //   Eight I/O registers at 0x20, sixteen data bytes at 0x40
    // Command word layout:
    //   Opcode in the low five bits; unknown codes run as a no-op
    //   Bit index picks the flag, the I/O bit or the operand bit
    //   I/O index picks one of the eight I/O registers
    //   Seven-bit signed offset for the relative branches
    // Sequencing, counted from the edge where the command write lands:
    //   The next edge runs the first execution cycle
    //   Single-cycle forms finish there and advance the PC by one
    //   Two-cycle forms finish one edge later
    //   Untaken branches take the short path, taken ones the long path
    //   Busy falls at the finishing edge and is polled in the status word
    // Flag effects:
    //   Shifts and rotates write Z, C, N and V, with V = N xor C
    //   S and H are never touched by a shift
    //   Swap, bit load, I/O bit ops, branches and loads keep all flags
    //   Bit store writes T only; flag set and clear write one bit
    // Bus timing:
    //   Every access has one wait state, more for a write while busy; pready stands for one cycle
    //   Read data is captured at the first access edge
    //   Narrow registers read back zeros in the upper bits
    //   Unmapped or misaligned addresses answer with pslverr, writes dropped
    //   Back-to-back transfers need no idle cycle between them
    //   A low clock enable freezes the bus handshake as well
    // Limitations:
    //   Loads see only the low four bits of X, the window is 16 bytes
    //   Data bytes are written only over the bus; loads never store
    //   Signed branches test N xor V, never the stored S bit
    //   The PC counts instructions, not program words
    //   No write lands while busy, so software cannot race the sequencer
    //   Reads stay open while busy, so the status word can be polled

    // Sequencer states
    localparam ST_IDLE = 2'b00;
    localparam ST_EX1 = 2'b01;
    localparam ST_EX2 = 2'b10;

    // Architectural state and the latched command
    reg [1:0] state_reg;
    reg [31:0] cmd_reg;
    reg [7:0] status_flag_register_reg;
    reg [15:0] pc_reg;
    reg [7:0] data_reg;
    reg [15:0] x_reg;
    reg taken_reg;

    // Flat views of the I/O registers and data bytes for the muxes
    wire [63:0] io_bus;
    wire [127:0] mem_bus;

    // Command fields
    wire [4:0] op = cmd_reg[`CBSE_F_OP_MSB:`CBSE_F_OP_LSB];
    wire [2:0] bit_sel = cmd_reg[`CBSE_F_BIT_MSB:`CBSE_F_BIT_LSB];
    wire [2:0] io_sel = cmd_reg[`CBSE_F_IO_MSB:`CBSE_F_IO_LSB];
    wire [6:0] k_ofs = cmd_reg[`CBSE_F_OFS_MSB:`CBSE_F_OFS_LSB];
    wire busy = (state_reg != ST_IDLE);

    // APB decode
    wire io_hit = (paddr[7:5] == `CBSE_IO_BASE_TAG) && (paddr[1:0] == 2'b00);
    wire mem_hit = (paddr[7:6] == `CBSE_MEM_BASE_TAG) && (paddr[1:0] == 2'b00);
    wire reg_hit = (paddr == `CBSE_OFS_CMD) || (paddr == `CBSE_OFS_STATUS) ||
                   (paddr == `CBSE_OFS_FLAGS) || (paddr == `CBSE_OFS_PC) ||
                   (paddr == `CBSE_OFS_DATA) || (paddr == `CBSE_OFS_XPTR);
    // Any mapped, aligned word
    wire addr_hit = io_hit || mem_hit || reg_hit;
    // Writes wait while an instruction runs, so software never races it
    wire can_accept = !(pwrite && busy);
    // Access phase qualifiers
    wire apb_first = psel && penable && !pready;
    wire apb_wr = psel && penable && pready && pwrite && addr_hit;
    wire cmd_wr = apb_wr && (paddr == `CBSE_OFS_CMD);

    // Sign-extended branch target
    wire [15:0] k_ext = {{9{k_ofs[6]}}, k_ofs};
    wire [15:0] pc_inc = pc_reg + 16'h0001;
    wire [15:0] pc_target = pc_reg + k_ext + 16'h0001;

    // Load operand from the data window, indexed by the low X bits
    wire [7:0] mem_at_x = mem_bus[x_reg[3:0]*8 +: 8];
    // Pointer steps for the load forms
    wire [15:0] x_dec = x_reg - 16'h0001;
    wire [15:0] x_inc = x_reg + 16'h0001;

    // Branch condition: index S tests N xor V instead of the stored S bit
    wire fl_n = status_flag_register_reg[`CBSE_FL_N];
    wire fl_v = status_flag_register_reg[`CBSE_FL_V];
    wire br_flag = (bit_sel == `CBSE_FL_S) ? (fl_n ^ fl_v) :
                   status_flag_register_reg[bit_sel];
    // Set form jumps on 1, clear form on 0
    wire br_take = (op == `CBSE_OP_BR_SET) ? br_flag : !br_flag;

    // Shifter result and its flags
    wire [7:0] sh_out;
    wire sh_c;
    wire sh_n = sh_out[7];
    wire sh_z = (sh_out == 8'h00);
    wire sh_v = sh_n ^ sh_c;

    cbse_shift_unit u_shift (
        .op(op),
        .din(data_reg),
        .cin(status_flag_register_reg[`CBSE_FL_C]),
        .dout(sh_out),
        .cout(sh_c)
    );

    // Instruction classes
    wire is_io = (op == `CBSE_OP_IO_SET) || (op == `CBSE_OP_IO_CLR);
    wire io_commit = clock_en && (state_reg == ST_EX2) && is_io;

    // I/O registers: APB writable, bit set/clear in the second cycle
    genvar gi;
    generate
        for (gi = 0; gi < `CBSE_IO_COUNT; gi = gi + 1) begin : g_io
            reg [7:0] q;
            wire sel_apb = apb_wr && io_hit && (paddr[4:2] == gi);
            always @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    q <= `CBSE_STORE_RST;
                end else if (clock_en) begin
                    if (io_commit && (io_sel == gi)) begin
                        if (op == `CBSE_OP_IO_SET)
                            q <= q | (8'h01 << bit_sel);
                        else
                            q <= q & ~(8'h01 << bit_sel);
                    end else if (sel_apb) begin
                        q <= pwdata[7:0];
                    end
                end
            end
            assign io_bus[gi*8 +: 8] = q;
        end
    endgenerate

    // Data window read by the X-pointer loads, written only over APB
    generate
        for (gi = 0; gi < `CBSE_MEM_COUNT; gi = gi + 1) begin : g_mem
            reg [7:0] q;
            wire sel_apb = apb_wr && mem_hit && (paddr[5:2] == gi);
            always @(posedge clock or negedge reset_n) begin
                if (!reset_n)
                    q <= `CBSE_STORE_RST;
                else if (clock_en && sel_apb)
                    q <= pwdata[7:0];
            end
            assign mem_bus[gi*8 +: 8] = q;
        end
    endgenerate

    // Read mux, captured one cycle before the access completes
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        if (io_hit) begin
            rd_data[7:0] = io_bus[paddr[4:2]*8 +: 8];
        end else if (mem_hit) begin
            rd_data[7:0] = mem_bus[paddr[5:2]*8 +: 8];
        end else begin
            case (paddr)
                `CBSE_OFS_CMD: rd_data = cmd_reg;
                `CBSE_OFS_STATUS: begin
                    rd_data[`CBSE_ST_BUSY] = busy;
                    rd_data[`CBSE_ST_TAKEN] = taken_reg;
                end
                `CBSE_OFS_FLAGS: rd_data[7:0] = status_flag_register_reg;
                `CBSE_OFS_PC: rd_data[15:0] = pc_reg;
                `CBSE_OFS_DATA: rd_data[7:0] = data_reg;
                `CBSE_OFS_XPTR: rd_data[15:0] = x_reg;
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    // APB handshake: one wait state, longer while busy blocks a write
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clock_en) begin
            if (pready) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end else if (apb_first && can_accept) begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h00000000 : rd_data;
                pslverr <= !addr_hit;
            end
        end
    end

    // Sequencer and core state; software writes land only while idle
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cmd_reg <= `CBSE_CMD_RST;
            status_flag_register_reg <= `CBSE_FLAGS_RST;
            pc_reg <= `CBSE_PC_RST;
            data_reg <= `CBSE_DATA_RST;
            x_reg <= `CBSE_X_RST;
            taken_reg <= 1'b0;
        end else if (clock_en) begin
            case (state_reg)
                // Idle: software owns every register
                ST_IDLE: begin
                    if (cmd_wr) begin
                        cmd_reg <= pwdata & `CBSE_CMD_MASK;
                        state_reg <= ST_EX1;
                    end else if (apb_wr) begin
                        if (paddr == `CBSE_OFS_FLAGS)
                            status_flag_register_reg <= pwdata[7:0];
                        if (paddr == `CBSE_OFS_PC)
                            pc_reg <= pwdata[15:0];
                        if (paddr == `CBSE_OFS_DATA)
                            data_reg <= pwdata[7:0];
                        if (paddr == `CBSE_OFS_XPTR)
                            x_reg <= pwdata[15:0];
                    end
                end
                ST_EX1: begin
                    // Single-cycle forms finish here; others go on to EX2
                    state_reg <= ST_IDLE;
                    pc_reg <= pc_inc;
                    taken_reg <= 1'b0;
                    case (op)
                        `CBSE_OP_BR_SET, `CBSE_OP_BR_CLR: begin
                            // Flags are left alone on every branch path
                            if (br_take) begin
                                taken_reg <= 1'b1;
                                pc_reg <= pc_reg;
                                state_reg <= ST_EX2;
                            end
                        end
                        `CBSE_OP_IO_SET, `CBSE_OP_IO_CLR: begin
                            pc_reg <= pc_reg;
                            state_reg <= ST_EX2;
                        end
                        `CBSE_OP_LSL, `CBSE_OP_LSR, `CBSE_OP_ROL,
                        `CBSE_OP_ROR, `CBSE_OP_ASHR: begin
                            data_reg <= sh_out;
                            status_flag_register_reg[`CBSE_FL_C] <= sh_c;
                            status_flag_register_reg[`CBSE_FL_Z] <= sh_z;
                            status_flag_register_reg[`CBSE_FL_N] <= sh_n;
                            status_flag_register_reg[`CBSE_FL_V] <= sh_v;
                        end
                        `CBSE_OP_SWAP: begin
                            data_reg <= sh_out;
                        end
                        `CBSE_OP_FLAG_SET: begin
                            status_flag_register_reg[bit_sel] <= 1'b1;
                        end
                        `CBSE_OP_FLAG_CLR: begin
                            status_flag_register_reg[bit_sel] <= 1'b0;
                        end
                        `CBSE_OP_TSTORE: begin
                            status_flag_register_reg[`CBSE_FL_T] <= data_reg[bit_sel];
                        end
                        `CBSE_OP_TLOAD: begin
                            data_reg[bit_sel] <= status_flag_register_reg[`CBSE_FL_T];
                        end
                        `CBSE_OP_LD_X, `CBSE_OP_LD_XINC: begin
                            data_reg <= mem_at_x;
                            pc_reg <= pc_reg;
                            state_reg <= ST_EX2;
                        end
                        `CBSE_OP_LD_XDEC: begin
                            x_reg <= x_dec;
                            pc_reg <= pc_reg;
                            state_reg <= ST_EX2;
                        end
                        default: begin
                            pc_reg <= pc_inc;
                        end
                    endcase
                end
                // Second cycle: branch target, pointer step or late load data
                ST_EX2: begin
                    state_reg <= ST_IDLE;
                    pc_reg <= pc_inc;
                    case (op)
                        `CBSE_OP_BR_SET, `CBSE_OP_BR_CLR: begin
                            pc_reg <= pc_target;
                        end
                        `CBSE_OP_LD_XINC: begin
                            x_reg <= x_inc;
                        end
                        `CBSE_OP_LD_XDEC: begin
                            data_reg <= mem_at_x;
                        end
                        default: begin
                            pc_reg <= pc_inc;
                        end
                    endcase
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// [rtl/cbse_shift_unit.v]
// Shift, rotate and nibble-swap datapath for the execution block.
// Purely combinational; the caller registers the result and flags.
`timescale 1ns/1ns
`include "cbse_regs.vh"

module cbse_shift_unit (
    input wire [4:0] op,
    input wire [7:0] din,
    input wire cin,
    output reg [7:0] dout,
    output reg cout
);

    // One shifter shared by all five shift forms and the swap
    always @* begin
        dout = din;
        cout = cin;
        case (op)
            `CBSE_OP_LSL: begin
                dout = {din[6:0], 1'b0};
                cout = din[7];
            end
            `CBSE_OP_LSR: begin
                dout = {1'b0, din[7:1]};
                cout = din[0];
            end
            `CBSE_OP_ROL: begin
                dout = {din[6:0], cin};
                cout = din[7];
            end
            `CBSE_OP_ROR: begin
                dout = {cin, din[7:1]};
                cout = din[0];
            end
            `CBSE_OP_ASHR: begin
                dout = {din[7], din[7:1]};
                cout = din[0];
            end
            `CBSE_OP_SWAP: begin
                dout = {din[3:0], din[7:4]};
            end
            default: begin
                dout = din;
            end
        endcase
    end

endmodule
